// >>> regulator_voltage_config_pkg.sv
// Constants for the regulator voltage configuration register bank
package regulator_voltage_config_pkg;
  localparam logic [7:0] ADDR_RAMP = 8'h07;
  localparam logic [7:0] ADDR_PAIR_A = 8'h08;
  localparam logic [7:0] ADDR_PAIR_B = 8'h09;
  localparam logic [7:0] ADDR_BUCK = 8'h0a;
  localparam logic [2:0] RAMP_RESET = 3'h6;
  localparam logic [2:0] RAMP_IMMEDIATE = 3'h7;
  localparam int HI_LSB = 4;
  localparam int HI_MSB = 6;
  localparam int LO_MSB = 2;
  localparam int BUCK_MSB = 5;
  // Default code sets for each pin combination, index = {pin_b, pin_a}
  // Packed as four 3-bit codes {four, three, two, one}, not hex nibbles
  localparam logic [11:0] PIN_DEF_LDO [4] = '{
    12'h000, 12'h249, 12'h492, 12'h6db};
  localparam logic [5:0] PIN_DEF_BUCK [4] = '{
    6'h10, 6'h08, 6'h14, 6'h17};
  // Ramp rate in units of 0.01 mV/us per code
  localparam logic [9:0] RAMP_SLOWEST = 10'h00b;
endpackage : regulator_voltage_config_pkg

// >>> regulator_voltage_config_regs.sv
// Register bank for ramp rate, linear regulator and buck voltage codes
`timescale 1ns/1ns
module regulator_voltage_config_regs
  import regulator_voltage_config_pkg::*;
#(
  parameter logic [11:0] LDO_DEF_TABLE [4] = PIN_DEF_LDO,
  parameter logic [5:0] BUCK_DEF_TABLE [4] = PIN_DEF_BUCK
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_lockout,
  input wire logic default_select_pin_a,
  input wire logic default_select_pin_b,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic [2:0] ramp_code,
  output logic ramp_immediate,
  output logic [9:0] ramp_rate,
  output logic [2:0] linear_reg_one,
  output logic [2:0] linear_reg_two,
  output logic [2:0] linear_reg_three,
  output logic [2:0] linear_reg_four,
  output logic [5:0] buck_one
);
  import regulator_voltage_config_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] ramp_reg;
  logic [2:0] lin1_reg, lin2_reg, lin3_reg, lin4_reg;
  logic [5:0] buck_reg;
  logic lockout_d_reg;
  logic load_defaults;
  logic [1:0] pin_idx;

  // Rate doubles per code up to 6, code 7 (immediate) decodes to zero; reported in 0.01 mV/us steps
  function automatic logic [9:0] ramp_decode(input logic [2:0] c);
    ramp_decode = (c == RAMP_IMMEDIATE) ? '0 : RAMP_SLOWEST << c;
  endfunction : ramp_decode

  assign pin_idx = {default_select_pin_b, default_select_pin_a};
  // Falling edge of lockout is the release; rst also counts as lockout
  assign load_defaults = rst | supply_lockout | lockout_d_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lockout_d_reg <= 1'b1;
    end else begin
      lockout_d_reg <= supply_lockout;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reload on lockout
  always_ff @(posedge core_clk) begin
    if (load_defaults) begin
      ramp_reg <= RAMP_RESET;
    end else if (wr_en && addr == ADDR_RAMP) begin
      ramp_reg <= wr_data[LO_MSB:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (load_defaults) begin
      {lin4_reg, lin3_reg, lin2_reg, lin1_reg} <= LDO_DEF_TABLE[pin_idx];
      buck_reg <= BUCK_DEF_TABLE[pin_idx];
    end else if (wr_en) begin
      case (addr)
        ADDR_PAIR_A: begin
          lin2_reg <= wr_data[HI_MSB:HI_LSB];
          lin1_reg <= wr_data[LO_MSB:0];
        end
        ADDR_PAIR_B: begin
          lin4_reg <= wr_data[HI_MSB:HI_LSB];
          lin3_reg <= wr_data[LO_MSB:0];
        end
        ADDR_BUCK: buck_reg <= wr_data[BUCK_MSB:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data registered; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      case (addr)
        ADDR_RAMP: rd_data <= {5'h0, ramp_reg};
        ADDR_PAIR_A: rd_data <= {1'b0, lin2_reg, 1'b0, lin1_reg};
        ADDR_PAIR_B: rd_data <= {1'b0, lin4_reg, 1'b0, lin3_reg};
        ADDR_BUCK: rd_data <= {2'h0, buck_reg};
        default: rd_data <= '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    ramp_code <= ramp_reg;
    ramp_immediate <= (ramp_reg == RAMP_IMMEDIATE);
    ramp_rate <= ramp_decode(ramp_reg);
    linear_reg_one <= lin1_reg;
    linear_reg_two <= lin2_reg;
    linear_reg_three <= lin3_reg;
    linear_reg_four <= lin4_reg;
    buck_one <= buck_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  property p_ramp_default;
    @(posedge core_clk) supply_lockout |=> ##1 ramp_code == RAMP_RESET;
  endproperty
  a_ramp_default: assert property (p_ramp_default)
    else $error("ramp default not loaded");

  property p_ramp_write;
    @(posedge core_clk) disable iff (rst)
      (!supply_lockout && !lockout_d_reg && wr_en && addr == ADDR_RAMP
       && !$past(supply_lockout)) |=> ##1 ramp_code == $past(wr_data[2:0], 2);
  endproperty
  a_ramp_write: assert property (p_ramp_write)
    else $error("ramp write lost");

  property p_ramp_decode;
    @(posedge core_clk) disable iff (rst)
      ramp_code == 3'h1 |-> ramp_rate == 10'h016;
  endproperty
  a_ramp_decode: assert property (p_ramp_decode)
    else $error("ramp rate decode wrong");

  property p_immediate;
    @(posedge core_clk) disable iff (rst)
      ramp_immediate |-> ramp_code == 3'h7 && ramp_rate == 10'h000;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate flag wrong");

  property p_read_pair_a;
    @(posedge core_clk) disable iff (rst)
      rd_en && addr == ADDR_PAIR_A |=> rd_data[7] == 1'b0
        && rd_data[3] == 1'b0 && rd_data[6:4] == $past(lin2_reg);
  endproperty
  a_read_pair_a: assert property (p_read_pair_a)
    else $error("pair a readback wrong");

  property p_read_pair_b;
    @(posedge core_clk) disable iff (rst)
      rd_en && addr == ADDR_PAIR_B |=> rd_data == {1'b0, $past(lin4_reg),
        1'b0, $past(lin3_reg)};
  endproperty
  a_read_pair_b: assert property (p_read_pair_b)
    else $error("pair b readback wrong");

  property p_read_buck;
    @(posedge core_clk) disable iff (rst)
      rd_en && addr == ADDR_BUCK |=> rd_data == {2'h0, $past(buck_reg)};
  endproperty
  a_read_buck: assert property (p_read_buck)
    else $error("buck readback wrong");

  property p_pins_ignored;
    @(posedge core_clk) disable iff (rst)
      (!supply_lockout && !lockout_d_reg && !wr_en) |=> $stable(buck_reg)
        && $stable(lin1_reg);
  endproperty
  a_pins_ignored: assert property (p_pins_ignored)
    else $error("field changed without write");

  property p_pin_default;
    @(posedge core_clk) supply_lockout |=> buck_reg == BUCK_DEF_TABLE[
      $past(pin_idx)];
  endproperty
  a_pin_default: assert property (p_pin_default)
    else $error("pin default not loaded");

  property p_read_ramp;
    @(posedge core_clk) disable iff (rst)
      rd_en && addr == ADDR_RAMP |=> rd_data == {5'h0, $past(ramp_reg)};
  endproperty
  a_read_ramp: assert property (p_read_ramp)
    else $error("ramp readback wrong");

  property p_lin_two_write;
    @(posedge core_clk) disable iff (rst)
      (!load_defaults && wr_en && addr == ADDR_PAIR_A) |=> ##1
        linear_reg_two == $past(wr_data[HI_MSB:HI_LSB], 2);
  endproperty
  a_lin_two_write: assert property (p_lin_two_write)
    else $error("regulator two code lost");

  property p_lin_one_write;
    @(posedge core_clk) disable iff (rst)
      (!load_defaults && wr_en && addr == ADDR_PAIR_A) |=> ##1
        linear_reg_one == $past(wr_data[LO_MSB:0], 2);
  endproperty
  a_lin_one_write: assert property (p_lin_one_write)
    else $error("regulator one code lost");

  property p_lin_four_write;
    @(posedge core_clk) disable iff (rst)
      (!load_defaults && wr_en && addr == ADDR_PAIR_B) |=> ##1
        linear_reg_four == $past(wr_data[HI_MSB:HI_LSB], 2);
  endproperty
  a_lin_four_write: assert property (p_lin_four_write)
    else $error("regulator four code lost");

  property p_buck_write;
    @(posedge core_clk) disable iff (rst)
      (!load_defaults && wr_en && addr == ADDR_BUCK) |=> ##1
        buck_one == $past(wr_data[BUCK_MSB:0], 2);
  endproperty
  a_buck_write: assert property (p_buck_write)
    else $error("buck code lost");
endmodule : regulator_voltage_config_regs

// >>> serial_host_model.sv
// Host model issuing register reads and writes
`timescale 1ns/1ns
module serial_host_model (
  input wire logic core_clk,
  input wire logic [7:0] rd_data,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wr_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  ////////////////////////////////////////
  // host writes new codes and reads registers back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge core_clk) #1;
    wr_en = 1'b0;
    // Stale bus shows inverted data
    wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge core_clk) #1;
    rd_en = 1'b0;
    addr = ~a;
    d = rd_data;
  endtask : rd
endmodule : serial_host_model

// >>> regulator_voltage_config_regs_bench.sv
// Self-checking bench for the voltage register bank
`timescale 1ns/1ns
module regulator_voltage_config_regs_bench;
  logic core_clk, rst, lock, pa, pb, wr_en, rd_en, ri;
  logic [7:0] addr, wr_data, rd_data, v;
  logic [2:0] rc, l1, l2, l3, l4;
  logic [9:0] rr;
  logic [5:0] bk;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  regulator_voltage_config_regs DUT (.core_clk(core_clk), .rst(rst),
    .supply_lockout(lock), .default_select_pin_a(pa),
    .default_select_pin_b(pb), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .ramp_code(rc),
    .ramp_immediate(ri), .ramp_rate(rr), .linear_reg_one(l1),
    .linear_reg_two(l2), .linear_reg_three(l3), .linear_reg_four(l4),
    .buck_one(bk));
  serial_host_model host (.core_clk(core_clk), .rd_data(rd_data),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s,
      input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // Pins flip after the load so late sampling shows up
  task automatic lockout(input logic b, input logic a);
    @(posedge core_clk) #1;
    lock = 1'b1;
    pb = b;
    pa = a;
    repeat (4) @(posedge core_clk);
    #1 lock = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 pb = ~b;
    pa = ~a;
  endtask : lockout
  task automatic sweep(input logic [31:0] e);
    for (int i = 0; i < 4; i++) begin
      host.rd(8'h07 + i[7:0], v);
      chk("reg", {8'h00, v}, {8'h00, e[8*i +: 8]});
    end
    chk("lin", {4'h0, l4, l3, l2, l1}, {4'h0, e[22:20], e[18:16],
      e[14:12], e[10:8]});
    chk("buck", {10'h000, bk}, {10'h000, e[29:24]});
    chk("ramp", {13'h0000, rc}, {13'h0000, e[2:0]});
  endtask : sweep
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    rst = 1'b1;
    lock = 1'b0;
    pa = 1'b0;
    pb = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    lockout(1'b1, 1'b0);
    sweep(32'h14_22_22_06);
    for (int i = 0; i < 5; i++) host.wr(8'h07 + i[7:0], 8'hff);
    sweep(32'h3f_77_77_07);
    host.rd(8'h0b, v);
    chk("unmapped", {8'h00, v}, 16'h0000);
    chk("imm", {15'h0000, ri}, 16'h0001);
    chk("rate7", {6'h00, rr}, 16'h0000);
    host.wr(8'h07, 8'h00);
    host.rd(8'h07, v);
    chk("rate0", {6'h00, rr}, 16'h000b);
    host.wr(8'h07, 8'h06);
    host.rd(8'h07, v);
    chk("rate6", {6'h00, rr}, 16'h02c0);
    chk("imm6", {15'h0000, ri}, 16'h0000);
    host.wr(8'h07, 8'h01);
    host.rd(8'h07, v);
    chk("rd1", {8'h00, v}, 16'h0001);
    chk("rate1", {6'h00, rr}, 16'h0016);
    lockout(1'b1, 1'b1);
    sweep(32'h17_33_33_06);
    end_sim();
  end
endmodule : regulator_voltage_config_regs_bench
